/* hdl/cacc_pkg.sv */
/*
  Constants shared by the capture/compare channel: APB register offsets,
  mode and control bit positions, reset values and widths.
  Assumes an APB master with 32-bit data and word-aligned byte addresses.
*/
package cacc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_PWMCTL = 8'h0c;
  localparam logic [7:0] OFS_CMP_LO = 8'h10;
  localparam logic [7:0] OFS_CMP_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam int ADDR_W = 8;

  // channel_mode_reg bits
  localparam int MB_PWM16 = 7;
  localparam int MB_ECOM = 6;
  localparam int MB_CAPP = 5;
  localparam int MB_CAPN = 4;
  localparam int MB_MAT = 3;
  localparam int MB_TOG = 2;
  localparam int MB_PWM = 1;
  localparam int MB_ECCF = 0;

  // pwm_control_reg bits
  localparam int PB_ARSEL = 7;
  localparam int PB_INTERMEDIATE_OVERFLOW_FLAG = 6;
  localparam int PB_ECOV = 5;
  localparam int PB_CYCLE_LENGTH_SEL_HI = 1;
  localparam int PB_CYCLE_LENGTH_SEL_LO = 0;

  // Control and status bits
  localparam int CB_RUN = 0;
  localparam int SB_CCF = 0;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PWMCTL_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [1:0] CYCLE_LENGTH_SEL_8 = 2'h0;
  localparam logic [1:0] CYCLE_LENGTH_SEL_9 = 2'h1;
  localparam logic [1:0] CYCLE_LENGTH_SEL_10 = 2'h2;
  localparam logic [7:0] BYTE_ONES = 8'hff;

  typedef enum logic [2:0] {
    MD_IDLE,
    MD_CAPTURE,
    MD_TIMER,
    MD_HSO,
    MD_FREQ,
    MD_PWM8,
    MD_PWM_ENABLE,
    MD_PWM16
  } cacc_mode_t;
endpackage

/* hdl/cacc_channel.sv */
/*
  One capture/compare channel of a counter array together with the shared
  16-bit counter it watches, reached by software over APB.
  Assumes CLK at 20 MHz, a synchronous active-low reset and a channel pin
  driven by an outside source or load; the counter advances once per
  enabled clock while the run bit is set.
  PWM outputs look one count ahead so that duty cycles come out exact.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
// Summary of operation
// - Capture copies full 16-bit counter on edge
// - Mode bits 5/4 pick rise, fall, both
// - Event flag stays set; only software clears
// - Mode bit 0 enables flag interrupt request
// - Timer mode: flag on 16-bit compare match
// - Low byte write clears, high sets comparator
// - High-speed mode toggles pin, sets flag
// - Comparator off: hold toggle pin, PWM low
// - Frequency mode: low match toggles, adds high
// - Frequency high byte zero means 256
// - Frequency mode flag on full 16-bit match
// - 8-bit PWM: high on match, low on wrap
// - 8-bit PWM reloads low from high byte
// - 8-bit PWM selection; flag on match
// - Cycle-length field selects 8 to 11 bits
// - Mode bit 7 selects 16-bit PWM
// - Shared cycle length; other modes independent
// - Intermediate overflow flag, optional interrupt
// - 8-bit PWM overflow every 256 counts
// - Auto-reload select steers compare byte access
module cacc_channel #(
  parameter int CNT_W = 16
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cacc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Channel pin
  input wire logic PIN_IN,
  output logic PIN_OUT,
  output logic PIN_OE_N,
  // Interrupt request
  output logic IRQ
);
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic run_ff, nxt_run;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] pwmctl_ff, nxt_pwmctl;
  logic [15:0] cmp_ff, nxt_cmp;
  logic [15:0] arl_ff, nxt_arl;
  logic ccf_ff, nxt_ccf;
  logic pin_ff, nxt_pin;
  logic oe_n_ff, nxt_oe_n;
  logic irq_ff, nxt_irq;
  logic sync1_ff, sync2_ff, prev_ff;
  logic nxt_sync1, nxt_sync2, nxt_prev;

  logic wr_acc, rd_acc, mapped;
  logic tick, rise, fall, edge_hit;
  logic full_match, lo_match, n_match, lo_wrap, n_wrap, cnt_wrap;
  // Look-ahead compares, used only by the PWM outputs
  logic lo_ahead, n_ahead, full_ahead;
  logic [15:0] nmask;
  cacc_pkg::cacc_mode_t mode;

  assign wr_acc = PSEL && PENABLE && pready_ff && PWRITE;
  assign rd_acc = PSEL && PENABLE && !pready_ff && !PWRITE;
  // Counter events need the run bit; capture works either way
  assign tick = run_ff;

  // Mode decode; cycle length only matters for 8 to 11-bit PWM
  // Frequency output wins when toggle and PWM are both set
  always_comb
  begin
    mode = cacc_pkg::MD_IDLE;
    if (mode_ff[cacc_pkg::MB_PWM])
    begin
      if (mode_ff[cacc_pkg::MB_TOG])
        mode = cacc_pkg::MD_FREQ;
      else if (mode_ff[cacc_pkg::MB_PWM16])
        mode = cacc_pkg::MD_PWM16;
      else if (pwmctl_ff[cacc_pkg::PB_CYCLE_LENGTH_SEL_HI:cacc_pkg::PB_CYCLE_LENGTH_SEL_LO]
               == cacc_pkg::CYCLE_LENGTH_SEL_8)
        mode = cacc_pkg::MD_PWM8;
      else
        mode = cacc_pkg::MD_PWM_ENABLE;
    end
    else if (mode_ff[cacc_pkg::MB_TOG])
      mode = cacc_pkg::MD_HSO;
    else if (mode_ff[cacc_pkg::MB_MAT])
      mode = cacc_pkg::MD_TIMER;
    else if (mode_ff[cacc_pkg::MB_CAPP] || mode_ff[cacc_pkg::MB_CAPN])
      mode = cacc_pkg::MD_CAPTURE;
  end

  // Cycle length mask: N low counter bits for the shared 8/9/10/11-bit width
  always_comb
  begin
    case (pwmctl_ff[cacc_pkg::PB_CYCLE_LENGTH_SEL_HI:cacc_pkg::PB_CYCLE_LENGTH_SEL_LO])
      cacc_pkg::CYCLE_LENGTH_SEL_8: nmask = 16'h00ff;
      cacc_pkg::CYCLE_LENGTH_SEL_9: nmask = 16'h01ff;
      cacc_pkg::CYCLE_LENGTH_SEL_10: nmask = 16'h03ff;
      // The last setting, 11 bits, is the widest window
      default: nmask = 16'h07ff;
    endcase
  end

  // Every comparison reads the one registered counter value
  assign full_match = tick && (cnt_ff[15:0] == cmp_ff);
  assign lo_match = tick && (cnt_ff[7:0] == cmp_ff[7:0]);
  assign n_match = tick && ((cnt_ff[15:0] & nmask) == (cmp_ff & nmask));
  // Wrap terms flag the last count before the low bits roll over
  assign lo_wrap = tick && (cnt_ff[7:0] == cacc_pkg::BYTE_ONES);
  assign n_wrap = tick && ((cnt_ff[15:0] & nmask) == nmask);
  assign cnt_wrap = tick && (&cnt_ff);
  // PWM pins are registered, so they are set on the count before and rise on the match;
  // the high time is then exactly the period minus the compare value
  assign lo_ahead = tick
                    && (cnt_ff[7:0] + cacc_pkg::ONE16[7:0] == cmp_ff[7:0]);
  assign n_ahead = tick
                   && (((cnt_ff[15:0] + cacc_pkg::ONE16) & nmask)
                       == (cmp_ff & nmask));
  assign full_ahead = tick && (cnt_ff[15:0] + cacc_pkg::ONE16 == cmp_ff);

  // Only the second stage is looked at for edges
  assign rise = sync2_ff && !prev_ff;
  assign fall = !sync2_ff && prev_ff;
  // Pulses shorter than one clock may be missed by the sampler
  assign edge_hit = (mode_ff[cacc_pkg::MB_CAPP] && rise)
                    || (mode_ff[cacc_pkg::MB_CAPN] && fall);

  // APB read mux and handshake; unmapped offsets answer with an error
  always_comb
  begin
    mapped = 1'b1;
    nxt_prdata = prdata_ff;
    case (PADDR)
      cacc_pkg::OFS_CTRL: nxt_prdata = {31'h0, run_ff};
      cacc_pkg::OFS_COUNT: nxt_prdata = {16'h0, cnt_ff[15:0]};
      cacc_pkg::OFS_MODE: nxt_prdata = {24'h0, mode_ff};
      cacc_pkg::OFS_PWMCTL: nxt_prdata = {24'h0, pwmctl_ff};
      cacc_pkg::OFS_CMP_LO:
        nxt_prdata = pwmctl_ff[cacc_pkg::PB_ARSEL] ?
          {24'h0, arl_ff[7:0]} : {24'h0, cmp_ff[7:0]};
      cacc_pkg::OFS_CMP_HI:
        nxt_prdata = pwmctl_ff[cacc_pkg::PB_ARSEL] ?
          {24'h0, arl_ff[15:8]} : {24'h0, cmp_ff[15:8]};
      cacc_pkg::OFS_STATUS: nxt_prdata = {31'h0, ccf_ff};
      default:
      begin
        mapped = 1'b0;
        nxt_prdata = 32'h0;
      end
    endcase
    if (!rd_acc)
      nxt_prdata = prdata_ff;
    // One wait state: answer in the second access cycle
    nxt_pready = PSEL && PENABLE && !pready_ff;
    nxt_pslverr = PSEL && PENABLE && !pready_ff && !mapped;
  end

  // Channel core next state
  always_comb
  begin
    nxt_run = run_ff;
    nxt_cnt = tick ? cnt_ff + CNT_W'(1) : cnt_ff;
    nxt_mode = mode_ff;
    nxt_pwmctl = pwmctl_ff;
    nxt_cmp = cmp_ff;
    nxt_arl = arl_ff;
    nxt_ccf = ccf_ff;
    nxt_pin = pin_ff;
    // Two synchroniser stages, then the previous sample for edges
    nxt_sync1 = PIN_IN;
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;

    // Software access comes first, hardware events then take priority
    if (wr_acc)
    begin
      case (PADDR)
        cacc_pkg::OFS_CTRL: nxt_run = PWDATA[cacc_pkg::CB_RUN];
        cacc_pkg::OFS_COUNT: nxt_cnt = PWDATA[CNT_W-1:0];
        cacc_pkg::OFS_MODE: nxt_mode = PWDATA[7:0];
        cacc_pkg::OFS_PWMCTL:
        begin
          nxt_pwmctl = PWDATA[7:0];
          // Overflow flag is write-one-to-clear
          nxt_pwmctl[cacc_pkg::PB_INTERMEDIATE_OVERFLOW_FLAG] = pwmctl_ff[cacc_pkg::PB_INTERMEDIATE_OVERFLOW_FLAG]
            && !PWDATA[cacc_pkg::PB_INTERMEDIATE_OVERFLOW_FLAG];
        end
        cacc_pkg::OFS_CMP_LO:
        begin
          if (pwmctl_ff[cacc_pkg::PB_ARSEL])
            nxt_arl[7:0] = PWDATA[7:0];
          else
            nxt_cmp[7:0] = PWDATA[7:0];
          // Comparator goes off even when the reload copy is written
          nxt_mode[cacc_pkg::MB_ECOM] = 1'b0;
        end
        cacc_pkg::OFS_CMP_HI:
        begin
          if (pwmctl_ff[cacc_pkg::PB_ARSEL])
            nxt_arl[15:8] = PWDATA[7:0];
          else
            nxt_cmp[15:8] = PWDATA[7:0];
          // Low byte first leaves the comparator on
          nxt_mode[cacc_pkg::MB_ECOM] = 1'b1;
        end
        cacc_pkg::OFS_STATUS:
          nxt_ccf = ccf_ff && !PWDATA[cacc_pkg::SB_CCF];
        default: ;
      endcase
    end

    // Overflow of the selected bit sets the flag, winning over a clear
    if (n_wrap)
      nxt_pwmctl[cacc_pkg::PB_INTERMEDIATE_OVERFLOW_FLAG] = 1'b1;

    // Hardware compare updates override a same-cycle software write
    case (mode)
      // Capture runs even with the counter stopped
      cacc_pkg::MD_CAPTURE:
        if (edge_hit && mode_ff[3:1] == 3'h0)
        begin
          nxt_cmp = cnt_ff[15:0];
          nxt_ccf = 1'b1;
        end
      // Timer sets the flag only; the pin is left alone
      cacc_pkg::MD_TIMER:
        if (mode_ff[cacc_pkg::MB_ECOM] && full_match)
          nxt_ccf = 1'b1;
      // Comparator off leaves the pin where it is
      cacc_pkg::MD_HSO:
        if (mode_ff[cacc_pkg::MB_ECOM] && full_match)
        begin
          nxt_pin = !pin_ff;
          if (mode_ff[cacc_pkg::MB_MAT])
            nxt_ccf = 1'b1;
        end
      cacc_pkg::MD_FREQ:
        if (mode_ff[cacc_pkg::MB_ECOM])
        begin
          if (lo_match)
          begin
            nxt_pin = !pin_ff;
            // A zero high byte adds nothing mod 256: a full 256 count
            nxt_cmp[7:0] = cmp_ff[7:0] + cmp_ff[15:8];
          end
          if (mode_ff[cacc_pkg::MB_MAT] && full_match)
            nxt_ccf = 1'b1;
        end
      cacc_pkg::MD_PWM8:
        if (!mode_ff[cacc_pkg::MB_ECOM])
          nxt_pin = 1'b0;
        else
        begin
          if (lo_wrap)
          begin
            // A zero reload value keeps the pin high: full duty
            nxt_pin = ~|cmp_ff[15:8];
            nxt_cmp[7:0] = cmp_ff[15:8];
          end
          else if (lo_ahead)
            nxt_pin = 1'b1;
          if (lo_match && mode_ff[cacc_pkg::MB_MAT])
            nxt_ccf = 1'b1;
        end
      // Nine to eleven bits reload from the auto-reload copy
      cacc_pkg::MD_PWM_ENABLE:
        if (!mode_ff[cacc_pkg::MB_ECOM])
          nxt_pin = 1'b0;
        else
        begin
          if (n_wrap)
          begin
            // The reloaded value decides the level of the first count
            nxt_pin = ~|(arl_ff & nmask);
            nxt_cmp = arl_ff & nmask;
          end
          else if (n_ahead)
            nxt_pin = 1'b1;
          if (n_match && mode_ff[cacc_pkg::MB_MAT])
            nxt_ccf = 1'b1;
        end
      // Sixteen-bit PWM ignores the shared cycle length
      cacc_pkg::MD_PWM16:
        if (!mode_ff[cacc_pkg::MB_ECOM])
          nxt_pin = 1'b0;
        else
        begin
          if (cnt_wrap)
            nxt_pin = ~|cmp_ff;
          else if (full_ahead)
            nxt_pin = 1'b1;
          if (full_match && mode_ff[cacc_pkg::MB_MAT])
            nxt_ccf = 1'b1;
        end
      default: ;
    endcase

    // Pin is driven only in modes that produce an output
    nxt_oe_n = !(nxt_mode[cacc_pkg::MB_TOG] || nxt_mode[cacc_pkg::MB_PWM]);
    nxt_irq = (nxt_ccf && nxt_mode[cacc_pkg::MB_ECCF])
              || (nxt_pwmctl[cacc_pkg::PB_INTERMEDIATE_OVERFLOW_FLAG]
                  && nxt_pwmctl[cacc_pkg::PB_ECOV]);
  end

  // Reset wins over the clock enable so a frozen block can still restart
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      run_ff <= 1'b0;
      cnt_ff <= '0;
      mode_ff <= cacc_pkg::MODE_RST;
      pwmctl_ff <= cacc_pkg::PWMCTL_RST;
      cmp_ff <= cacc_pkg::CMP_RST;
      arl_ff <= cacc_pkg::CMP_RST;
      ccf_ff <= 1'b0;
      pin_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      irq_ff <= 1'b0;
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else if (CE)
    begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      run_ff <= nxt_run;
      cnt_ff <= nxt_cnt;
      mode_ff <= nxt_mode;
      pwmctl_ff <= nxt_pwmctl;
      cmp_ff <= nxt_cmp;
      arl_ff <= nxt_arl;
      ccf_ff <= nxt_ccf;
      pin_ff <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
      irq_ff <= nxt_irq;
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  // Every output is a flip-flop: no path from an input to an output
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign PRDATA = prdata_ff;
  assign PIN_OUT = pin_ff;
  assign PIN_OE_N = oe_n_ff;
  assign IRQ = irq_ff;
endmodule

/* sim/cacc_channel_sva.sv */
/*
  Port checker for the capture/compare channel, bound into cacc_channel.
  Assumes CE held high and a mode byte known only through APB writes.
*/
module cacc_channel_sva #(
  parameter int CNT_W = 16
) (
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cacc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pin and interrupt
  input wire logic PIN_IN,
  input wire logic PIN_OUT,
  input wire logic PIN_OE_N,
  input wire logic IRQ
);
  logic [7:0] mode_ff;
  logic ecov_ff;
  logic wr;
  assign wr = PSEL && PENABLE && PREADY && PWRITE && CE;
  // Shadow mode byte; compare writes move the comparator bit
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      mode_ff <= cacc_pkg::MODE_RST;
    else if (wr && PADDR == cacc_pkg::OFS_MODE)
      mode_ff <= PWDATA[7:0];
    else if (wr && PADDR == cacc_pkg::OFS_CMP_LO)
      mode_ff[cacc_pkg::MB_ECOM] <= 1'b0;
    else if (wr && PADDR == cacc_pkg::OFS_CMP_HI)
      mode_ff[cacc_pkg::MB_ECOM] <= 1'b1;
  end
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      ecov_ff <= 1'b0;
    else if (wr && PADDR == cacc_pkg::OFS_PWMCTL)
      ecov_ff <= PWDATA[cacc_pkg::PB_ECOV];
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_wait: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_reset_quiet: assert property (disable iff (1'b0)
    !NRST |=> !PREADY && !PSLVERR && !IRQ && !PIN_OUT && PIN_OE_N)
    else $error("outputs active after reset");
  a_irq_sticky: assert property (
    $fell(IRQ) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt dropped without a write");
  a_irq_enabled: assert property (
    $rose(IRQ) |-> mode_ff[cacc_pkg::MB_ECCF] || ecov_ff)
    else $error("interrupt without enable");
  a_capture_rise: assert property (
    $rose(PIN_IN) && mode_ff[3:1] == 3'h0 && mode_ff[5] && mode_ff[0]
    |-> ##[1:6] IRQ)
    else $error("rising edge not captured");
  a_fall_only: assert property (
    $rose(PIN_IN) && !IRQ && mode_ff[5:0] == 6'h11 |=> !IRQ [*4])
    else $error("rising edge captured in fall mode");
  a_pwm_off_low: assert property (
    (mode_ff[1] && !mode_ff[2] && !mode_ff[6]) [*3] |-> !PIN_OUT)
    else $error("pwm output high with comparator off");
  a_toggle_hold: assert property (
    (mode_ff[2] && !mode_ff[6]) [*3] |-> $stable(PIN_OUT))
    else $error("pin toggled with comparator off");
endmodule

bind cacc_channel cacc_channel_sva #(.CNT_W(CNT_W)) chk (
  .CLK(CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE_N(PIN_OE_N), .IRQ(IRQ)
);

/* sim/cacc_pin_src.sv */
/*
  Outside signal source on the channel pin.
  Follows the requested level but never changes within two clocks.
*/
module cacc_pin_src (
  // Clock and requested level
  input wire logic clk,
  input wire logic want,
  // Level driven onto the pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] held = 2'h0;
  initial pin = 1'b0;
  // A request arriving too soon waits, so no level lasts under three clocks on the pin
  always @(posedge clk)
  begin
    if (want != pin && held == 2'h2)
    begin
      pin <= want;
      held <= 2'h0;
    end
    else if (held != 2'h2)
      held <= held + 2'h1;
  end
endmodule

/* sim/counter_array_capture_compare_channel_bench.sv */
/*
  Self-checking bench for cacc_channel: APB master, pin source, checks.
  Assumes the checker is bound in; CE drops once, with no bus traffic.
*/
module counter_array_capture_compare_channel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic want = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'h0db7;
  logic [15:0] v, r, cap;
  logic [7:0] h;
  logic err, hit;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, pin_in, pin_out, pin_oe_n, irq, src_pin;
  int n_errors = 0;
  int check_count = 0;
  int n;

  always #25 clk = ~clk;
  // Wire level: the channel wins while it drives
  assign pin_in = pin_oe_n ? src_pin : pin_out;

  cacc_channel uut (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .IRQ(irq));
  cacc_pin_src src (.clk(clk), .want(want), .pin(src_pin));

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    check("pready", pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_exp(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  task automatic wait_toggle(output int k);
    logic p;
    p = pin_out;
    k = 0;
    while (pin_out === p && k < 600)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    n_errors++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4)
    begin
      rd_exp("reset value", 8'(a), 32'h0);
      check("slverr", err, a == 28);
    end
    apb(1'b1, 8'h1c, 32'h1);
    check("slverr write", err, 1'b1);
    v = 16'(next_rand()) | 16'h0100;
    apb(1'b1, cacc_pkg::OFS_MODE, 32'h49);
    apb(1'b1, cacc_pkg::OFS_CMP_LO, v[7:0]);
    rd_exp("mode lo", cacc_pkg::OFS_MODE, 32'h09);
    apb(1'b1, cacc_pkg::OFS_CMP_HI, v[15:8]);
    rd_exp("mode hi", cacc_pkg::OFS_MODE, 32'h49);
    apb(1'b1, cacc_pkg::OFS_COUNT, v - 16'd40);
    rd_exp("early flag", cacc_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, cacc_pkg::OFS_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    apb(1'b1, cacc_pkg::OFS_CTRL, 32'h0);
    rd_exp("timer flag", cacc_pkg::OFS_STATUS, 32'h1);
    check("timer irq", irq, 1'b1);
    apb(1'b1, cacc_pkg::OFS_STATUS, 32'h1);
    check("irq cleared", irq, 1'b0);
    apb(1'b1, cacc_pkg::OFS_MODE, 32'h0c);
    // Second pass leaves the comparator off, so the pin must keep its level
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, cacc_pkg::OFS_CMP_LO, v[7:0]);
      if (k == 0)
        apb(1'b1, cacc_pkg::OFS_CMP_HI, v[15:8]);
      apb(1'b1, cacc_pkg::OFS_COUNT, v - 16'd20);
      apb(1'b1, cacc_pkg::OFS_CTRL, 32'h1);
      repeat (40) @(posedge clk);
      apb(1'b1, cacc_pkg::OFS_CTRL, 32'h0);
      check("hso pin", pin_out, 1'b1);
      check("hso drive", pin_oe_n, 1'b0);
      rd_exp("hso flag", cacc_pkg::OFS_STATUS, k == 0);
      apb(1'b1, cacc_pkg::OFS_STATUS, 32'h1);
    end
    // Source matches the driven high level, so leaving the output
    // modes makes no edge; the first toggle below is then a fall
    want <= 1'b1;
    repeat (3) @(posedge clk);
    cap = v;
    for (int m = 1; m < 4; m++)
    begin
      apb(1'b1, cacc_pkg::OFS_MODE, {m[1:0], 4'h1});
      for (int e = 0; e < 2; e++)
      begin
        r = 16'(next_rand());
        apb(1'b1, cacc_pkg::OFS_COUNT, r);
        want <= ~want;
        if (m == 1 && e == 0)
        begin
          // A frozen clock enable must hold off the edge detector
          ce <= 1'b0;
          repeat (10) @(posedge clk);
          check("frozen irq", irq, 1'b0);
          ce <= 1'b1;
        end
        repeat (10) @(posedge clk);
        hit = e ? m[1] : m[0];
        if (hit)
          cap = r;
        check("capture irq", irq, hit);
        check("capture drive", pin_oe_n, 1'b1);
        rd_exp("capture flag", cacc_pkg::OFS_STATUS, hit);
        rd_exp("capture lo", cacc_pkg::OFS_CMP_LO, cap[7:0]);
        rd_exp("capture hi", cacc_pkg::OFS_CMP_HI, cap[15:8]);
        apb(1'b1, cacc_pkg::OFS_STATUS, 32'h1);
      end
    end
    h = 8'(next_rand()) | 8'h01;
    apb(1'b1, cacc_pkg::OFS_PWMCTL, 32'h0);
    apb(1'b1, cacc_pkg::OFS_MODE, 32'h42);
    apb(1'b1, cacc_pkg::OFS_CMP_LO, h ^ 8'h5a);
    apb(1'b1, cacc_pkg::OFS_CMP_HI, h);
    apb(1'b1, cacc_pkg::OFS_COUNT, 32'h0);
    apb(1'b1, cacc_pkg::OFS_CTRL, 32'h1);
    repeat (300) @(posedge clk);
    n = 0;
    repeat (256)
    begin
      @(posedge clk);
      n += pin_out;
    end
    check("pwm duty", 32'(n), 32'(256 - h));
    rd_exp("overflow flag", cacc_pkg::OFS_PWMCTL, 32'h40);
    apb(1'b1, cacc_pkg::OFS_CMP_LO, h);
    repeat (300) @(posedge clk);
    check("pwm off", pin_out, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      h = k ? 8'h00 : (8'(next_rand()) & 8'h3f) | 8'h04;
      apb(1'b1, cacc_pkg::OFS_MODE, 32'h46);
      apb(1'b1, cacc_pkg::OFS_CMP_LO, 32'h0);
      apb(1'b1, cacc_pkg::OFS_CMP_HI, h);
      wait_toggle(n);
      wait_toggle(n);
      check("half period", 32'(n), k ? 32'd256 : h);
    end
    apb(1'b1, cacc_pkg::OFS_PWMCTL, 32'h80);
    apb(1'b1, cacc_pkg::OFS_CMP_HI, 32'h5a);
    rd_exp("reload hi", cacc_pkg::OFS_CMP_HI, 32'h5a);
    apb(1'b1, cacc_pkg::OFS_PWMCTL, 32'h0);
    rd_exp("compare hi", cacc_pkg::OFS_CMP_HI, 32'h0);
    test_done();
  end
endmodule
